// [hw/aci_pkg.sv]
// Package: modes, timing and cell constants for the cell inlet link
package aci_pkg;
    // Operating modes of the inlet port
    typedef enum logic [3:0] {
        MODE_ATM = 4'h1,
        MODE_PHY = 4'h2,
        MODE_B2B = 4'h4,
        MODE_ALI = 4'h8
    } aci_mode_e;
    localparam int CELL_BYTES = 53;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_LAST = 6'h34;
    localparam int DATA_W = 8;
    // Transfer clock divider, an enable pulse every CLK_DIV system cycles
    localparam int CLK_DIV = 4;
    localparam logic [1:0] DIV_LAST = 2'h3;
    localparam int BUF_DEPTH = 2;
endpackage

// [hw/aci_link_if.sv]
// Interface: pins between the inlet port and its cell partner
`timescale 1ns/1ps
interface aci_link_if;
    import aci_pkg::*;
    logic [7:0] inletDataBus;
    logic inletStartOfCell;
    logic cavDev;
    logic cavDevOe;
    logic cavPtn;
    logic cavPtnOe;
    logic clkDev;
    logic clkDevOe;
    logic clkPtn;
    logic clkPtnOe;
    logic enDev;
    logic enDevOe;
    logic enPtn;
    logic enPtnOe;
    logic inletAckFlag;
    logic inletFlagTwo;
    logic inletNackFlag;
    logic inletFlagFour;
    logic inletCellAvailable;
    logic inletTransferClock;
    logic inletEnableN;
    // Wire levels resolved from enables; undriven enable reads high
    assign inletCellAvailable = cavDevOe ? cavDev : (cavPtnOe ? cavPtn : 1'b0);
    assign inletTransferClock = clkDevOe ? clkDev : (clkPtnOe ? clkPtn : 1'b0);
    assign inletEnableN = enDevOe ? enDev : (enPtnOe ? enPtn : 1'b1);
    modport dev (
        input inletDataBus, inletStartOfCell, inletFlagTwo, inletFlagFour,
        input inletCellAvailable, inletTransferClock, inletEnableN,
        output cavDev, cavDevOe, clkDev, clkDevOe, enDev, enDevOe,
        output inletAckFlag, inletNackFlag
    );
    modport ptn (
        output inletDataBus, inletStartOfCell, inletFlagTwo, inletFlagFour,
        output cavPtn, cavPtnOe, clkPtn, clkPtnOe, enPtn, enPtnOe,
        input inletCellAvailable, inletTransferClock, inletEnableN,
        input inletAckFlag, inletNackFlag
    );
endinterface

// [hw/aci_partner.sv]
// Partner end: sends cells from a user stream onto the inlet pins
`timescale 1ns/1ps
module aci_partner
    import aci_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire aci_mode_e mode,
    aci_link_if.ptn link,
    input wire logic [7:0] txData,
    input wire logic txSoc,
    input wire logic txValid,
    output logic txReady,
    input wire logic flushDone,
    input wire logic extInterrupt,
    input wire logic parityBit,
    output logic ackSeen,
    output logic nackSeen
);
    typedef struct packed {
        logic [1:0] div;
        logic clkLvl;
        logic enN;
        logic [7:0] data;
        logic soc;
        logic ack;
        logic nack;
        logic clkPrev;
    } aci_ptn_s;
    aci_ptn_s st_r, st_nxt;
    logic phy, ali, edgeDev, tick;
    assign phy = (mode == MODE_PHY);
    assign ali = (mode == MODE_ALI);
    // Rising edge of the device-made clock, pin taken as synchronous
    assign edgeDev = link.inletTransferClock && !st_r.clkPrev;
    assign tick = phy ? (st_r.div == DIV_LAST) : edgeDev;
    // PHY mode: partner makes the clock and drives the enable
    assign link.clkPtn = st_r.clkLvl;
    assign link.clkPtnOe = phy;
    assign link.enPtn = st_r.enN;
    assign link.enPtnOe = phy;
    // Cell available from partner when it holds a word
    assign link.cavPtn = ali ? txValid : txValid;
    assign link.cavPtnOe = !phy;
    assign link.inletDataBus = st_r.data;
    assign link.inletStartOfCell = ali ? parityBit : st_r.soc;
    assign link.inletFlagTwo = flushDone;
    assign link.inletFlagFour = extInterrupt;
    // Presents a new word only on a transfer edge the device accepts
    assign txReady = tick && (phy ? link.inletCellAvailable
                                  : !link.inletEnableN);
    assign ackSeen = st_r.ack;
    assign nackSeen = st_r.nack;
    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.clkPrev = link.inletTransferClock;
        st_nxt.div = st_r.div + 2'h1;
        if (st_r.div == DIV_LAST)
        begin
            st_nxt.clkLvl = 1'b1;
        end
        else if (st_r.div == 2'h1)
        begin
            st_nxt.clkLvl = 1'b0;
        end
        if (tick)
        begin
            st_nxt.enN = !(txValid && link.inletCellAvailable);
            if (txReady && txValid)
            begin
                st_nxt.data = txData;
                st_nxt.soc = txSoc;
            end
        end
        // Flags disregarded in ALI mode
        st_nxt.ack = link.inletAckFlag && !ali;
        st_nxt.nack = link.inletNackFlag && !ali;
    end
    // State register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '{div: 2'h0, clkLvl: 1'b0, enN: 1'b1, data: 8'h00,
                      soc: 1'b0, ack: 1'b0, nack: 1'b0, clkPrev: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule

// [hw/aci_inlet.sv]
// Device end: the cell inlet port with mode-dependent pin directions
//
// How it works
// - ATM mode: partner's cell-available is input
// - PHY mode: device drives cell-available when roomy
// - Back-to-back: cell-available is partner-driven input
// - ALI mode: cell-available is receive-valid input
// - Transfers happen on transfer clock rising edge
// - ATM mode: device generates transfer clock
// - PHY mode: partner supplies the transfer clock
// - Back-to-back and ALI: device drives clock
// - Data arrives as eight parallel bits
// - ATM/back-to-back: device drives enable, low active
// - PHY mode: partner drives enable, sampled next
// - ALI mode: enable pin is receive-load output
// - Ack flag high per good cell; flush
// - Flag two ignored except flush-done in ALI
// - Nack flag high per rejected cell, except in ALI where it stays low
// - ALI mode: flag four is external interrupt
// - Start-of-cell marks a cell's first byte
// - ALI parity bit is neither checked nor used
`timescale 1ns/1ps
module aci_inlet
    import aci_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire aci_mode_e mode,
    aci_link_if.dev link,
    output logic [7:0] rxData,
    output logic rxSoc,
    output logic rxValid,
    input wire logic rxReady,
    input wire logic flushReq,
    output logic flushDone,
    output logic extInterrupt,
    output logic cellGood,
    output logic cellBad
);
    // Elaboration-time check: the buffer logic serves two entries only
    if (DEPTH != 2)
    begin : g_bad_depth
        $error("aci_inlet: buffer depth must be 2");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] div;
        logic clkLvl;
        logic enN;
        logic clkPrev;
        logic [CNT_W-1:0] cnt;
        logic inCell;
        logic ack;
        logic nack;
        logic flush;
        logic [1:0][8:0] buf_;
        logic [1:0] fill;
    } aci_dev_s;
    aci_dev_s st_r, st_nxt;
    logic atm, phy, b2b, ali, devClk, tick, take, pop, full, room;

    assign atm = (mode == MODE_ATM);
    assign phy = (mode == MODE_PHY);
    assign b2b = (mode == MODE_B2B);
    assign ali = (mode == MODE_ALI);
    assign devClk = !phy;
    assign full = (st_r.fill == 2'h2);
    // Room for a byte means the receiver's stall backs up the link
    assign room = !full;

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Clock: device divides its own clock except in PHY mode
    assign link.clkDev = st_r.clkLvl;
    assign link.clkDevOe = devClk;
    // Cell-available driven out only in PHY mode
    assign link.cavDev = room;
    assign link.cavDevOe = phy;
    // Enable, or receive-load in ALI, driven out when device clocks
    assign link.enDev = st_r.enN;
    assign link.enDevOe = devClk;
    assign link.inletAckFlag = ali ? st_r.flush : st_r.ack;
    assign link.inletNackFlag = ali ? 1'b0 : st_r.nack;
    // Flag two only means something in ALI mode
    assign flushDone = ali && link.inletFlagTwo;
    assign extInterrupt = ali && link.inletFlagFour;

    // ------------------------------------------------------------
    // Transfer timing
    // ------------------------------------------------------------
    // One tick per transfer clock rising edge, from either source
    assign tick = devClk ? (st_r.div == DIV_LAST)
                         : (link.inletTransferClock && !st_r.clkPrev);
    // The partner loads a byte on the same tick at which it first sees enable low, so
    // the byte is taken on the next tick while enable is still low
    assign take = tick && !link.inletEnableN;
    assign pop = rxValid && rxReady;
    assign rxValid = (st_r.fill != 2'h0);
    assign rxData = st_r.buf_[0][7:0];
    assign rxSoc = st_r.buf_[0][8];
    assign cellGood = st_r.ack;
    assign cellBad = st_r.nack;

    // Next-state logic
    always_comb
    begin
        logic [8:0] word;
        logic sop;
        logic [1:0] fillMid;
        word = 9'h000;
        sop = 1'b0;
        fillMid = 2'h0;
        st_nxt = st_r;
        st_nxt.clkPrev = link.inletTransferClock;
        st_nxt.div = st_r.div + 2'h1;
        if (st_r.div == DIV_LAST)
        begin
            st_nxt.clkLvl = 1'b1;
        end
        else if (st_r.div == 2'h1)
        begin
            st_nxt.clkLvl = 1'b0;
        end
        st_nxt.ack = 1'b0;
        st_nxt.nack = 1'b0;
        st_nxt.flush = flushReq && ali;
        // Pop from the head first, so a full buffer can refill at once
        fillMid = st_r.fill;
        if (pop)
        begin
            st_nxt.buf_[0] = st_r.buf_[1];
            fillMid = st_r.fill - 2'h1;
        end
        if (tick)
        begin
            // Enable drive: only when partner signals and the buffer is empty after the pop
            if (devClk)
            begin
                st_nxt.enN = !(link.inletCellAvailable && fillMid == 2'h0);
            end
        end
        if (take)
        begin
            // Parity on start-of-cell pin is dropped in ALI mode
            sop = ali ? (st_r.cnt == 6'h00 && !st_r.inCell)
                      : link.inletStartOfCell;
            word = {sop, link.inletDataBus};
            if (fillMid == 2'h2)
            begin
                // Overrun: a byte with nowhere to go spoils the cell
                st_nxt.inCell = 1'b0;
                st_nxt.cnt = 6'h00;
                st_nxt.nack = !ali;
            end
            else
            begin
                st_nxt.buf_[fillMid[0]] = word;
                fillMid = fillMid + 2'h1;
                if (sop)
                begin
                    // Early start-of-cell aborts the partial cell
                    st_nxt.nack = st_r.inCell && !ali;
                    st_nxt.inCell = 1'b1;
                    st_nxt.cnt = 6'h01;
                end
                else if (st_r.inCell)
                begin
                    if (st_r.cnt == CNT_LAST)
                    begin
                        // Pulse kept in ALI too; the pin shows flush there
                        st_nxt.ack = 1'b1;
                        st_nxt.inCell = 1'b0;
                        st_nxt.cnt = 6'h00;
                    end
                    else
                    begin
                        st_nxt.cnt = st_r.cnt + 6'h01;
                    end
                end
            end
        end
        st_nxt.fill = fillMid;
    end

    // State register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '0;
            st_r.enN <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule

// [verif/aci_link_properties.sv]
// Checker: pin directions and flag timing on the inlet link
`timescale 1ns/1ps
module aci_link_properties
    import aci_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire aci_mode_e mode,
    input wire logic cavDevOe,
    input wire logic cavPtnOe,
    input wire logic clkDevOe,
    input wire logic enDevOe,
    input wire logic inletAckFlag,
    input wire logic inletNackFlag
);
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // One edge of grace, since pin enables may be registered from mode
    chk_atm_cav_in: assert property (mode == MODE_ATM |=> !cavDevOe)
        else $error("cav driven in atm mode");
    chk_phy_cav_out: assert property (mode == MODE_PHY |=> cavDevOe)
        else $error("cav not driven in phy mode");
    chk_b2b_cav_in: assert property (mode == MODE_B2B |=> !cavDevOe)
        else $error("cav driven in b2b mode");
    chk_ali_valid_in: assert property (mode == MODE_ALI |=> !cavDevOe)
        else $error("valid driven in ali mode");
    chk_atm_clk_out: assert property (mode == MODE_ATM |=> clkDevOe)
        else $error("clock not driven in atm mode");
    chk_phy_clk_in: assert property (mode == MODE_PHY |=> !clkDevOe)
        else $error("clock driven in phy mode");
    chk_b2b_clk_out: assert property (mode inside {MODE_B2B, MODE_ALI}
        |=> clkDevOe)
        else $error("clock not driven in b2b or ali mode");
    chk_dev_enable_out: assert property (mode inside {MODE_ATM, MODE_B2B}
        |=> enDevOe)
        else $error("enable not driven");
    chk_phy_enable_in: assert property (mode == MODE_PHY |=> !enDevOe)
        else $error("enable driven in phy mode");
    chk_ali_load_out: assert property (mode == MODE_ALI |=> enDevOe)
        else $error("load not driven in ali mode");
    chk_ack_one_cycle: assert property (mode != MODE_ALI
        && $rose(inletAckFlag) |=> $fell(inletAckFlag))
        else $error("ack longer than one cycle");
    chk_nack_ali_low: assert property (mode == MODE_ALI |=> !inletNackFlag)
        else $error("nack high in ali mode");
    chk_ack_nack_excl: assert property (!(inletAckFlag && inletNackFlag)
        || mode == MODE_ALI)
        else $error("ack and nack together");
endmodule

// [verif/testbench.sv]
// Testbench: both ends of the inlet link joined back to back
`timescale 1ns/1ps
module testbench;
    import aci_pkg::*;
    logic clk = 0;
    logic resetn = 0;
    aci_mode_e mode = MODE_ATM;
    logic [7:0] txData = 8'h00;
    logic txSoc = 0, txValid = 0, rxReady = 1, flushReq = 0;
    logic pFlush = 0, pInt = 0, parity = 0, txFire = 0;
    logic txReady, rxSoc, rxValid, dFlush, dInt, good, bad, ackS, nackS;
    logic [7:0] rxData;
    logic [8:0] rxq[$];
    int err_count = 0, samples_checked = 0;
    int goodN, badN, ackN, nackN;
    aci_link_if link();
    aci_inlet aci_inlet_i (.clk(clk), .resetn(resetn), .mode(mode),
        .link(link), .rxData(rxData), .rxSoc(rxSoc), .rxValid(rxValid),
        .rxReady(rxReady), .flushReq(flushReq), .flushDone(dFlush),
        .extInterrupt(dInt), .cellGood(good), .cellBad(bad));
    aci_partner aci_partner_i (.clk(clk), .resetn(resetn), .mode(mode),
        .link(link), .txData(txData), .txSoc(txSoc), .txValid(txValid),
        .txReady(txReady), .flushDone(pFlush), .extInterrupt(pInt),
        .parityBit(parity), .ackSeen(ackS), .nackSeen(nackS));
    aci_link_properties aci_link_properties_i (.clk(clk), .resetn(resetn),
        .mode(mode), .cavDevOe(link.cavDevOe), .cavPtnOe(link.cavPtnOe),
        .clkDevOe(link.clkDevOe), .enDevOe(link.enDevOe),
        .inletAckFlag(link.inletAckFlag),
        .inletNackFlag(link.inletNackFlag));
    // ----------------
    // Clock, monitor and tasks
    // ----------------
    initial forever #4 clk = ~clk;
    // Log popped bytes and count flag pulses, sampled before edge updates
    always @(posedge clk)
    begin
        txFire <= txValid && txReady;
        if (rxValid && rxReady) rxq.push_back({rxSoc, rxData});
        goodN += good;
        badN += bad;
        ackN += ackS;
        nackN += nackS;
    end
    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // Mode only changes under reset, so pins never swap mid-cell
    task rst(input aci_mode_e m);
        resetn = 0;
        mode = m;
        repeat (8) @(negedge clk);
        resetn = 1;
        rxq.delete();
        {goodN, badN, ackN, nackN} = '0;
    endtask
    task send(input logic [7:0] b, input int n);
        int w;
        for (int k = 0; k < n; k++)
        begin
            txData = b + 8'(k);
            txSoc = (k == 0);
            txValid = 1;
            w = 0;
            do
            begin
                @(posedge clk);
                #1 w++;
            end while (!txFire && w < 900);
            @(negedge clk);
        end
        txValid = 0;
        @(negedge clk);
    endtask
    task expect_cell(input logic [7:0] b);
        int w;
        w = 0;
        while (rxq.size() < 53 && w < 3000)
        begin
            @(negedge clk);
            w++;
        end
        repeat (8) @(negedge clk);
        check("bytes", 53, rxq.size());
        for (int k = 0; k < rxq.size(); k++)
            check("byte", {k == 0, 8'(b + k)}, rxq[k]);
        check("good", 1, goodN);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Whole run is some 1600 cycles; this cuts a hang short
    initial
    begin
        #200000;
        err_count++;
        finish_test;
    end
    // ----------------
    // Tests
    // ----------------
    initial
    begin
        aci_mode_e ms[3];
        ms = '{MODE_ATM, MODE_PHY, MODE_B2B};
        for (int i = 0; i < 3; i++)
        begin
            @(negedge clk);
            rst(ms[i]);
            pFlush = 1;
            send(8'(16 * i + 1), 53);
            expect_cell(8'(16 * i + 1));
            check("flag two", 0, dFlush);
            check("ack", 1, ackN);
            check("nack", 0, nackN);
            pFlush = 0;
            $display("cell test done in mode %0h", mode);
        end
        // Receiver stalls: buffer fills, pins refuse, no byte is lost
        rst(MODE_PHY);
        rxReady = 0;
        fork
            send(8'h60, 53);
            begin
                repeat (100) @(negedge clk);
                check("held", 0, rxq.size());
                check("valid", 1, rxValid);
                check("cav", 0, link.inletCellAvailable);
                rxReady = 1;
            end
        join
        expect_cell(8'h60);
        $display("stall test done");
        // Short cell cut by a new start is rejected, next one accepted
        rst(MODE_B2B);
        send(8'hA0, 20);
        send(8'h30, 53);
        repeat (20) @(negedge clk);
        check("bad", 1, badN);
        check("nack", 1, nackN);
        check("good", 1, goodN);
        $display("short cell test done");
        // ALI: flush, flush-done, interrupt, parity ignored
        rst(MODE_ALI);
        flushReq = 1;
        @(negedge clk);
        check("flush", 1, link.inletAckFlag);
        flushReq = 0;
        pFlush = 1;
        pInt = 1;
        parity = 1;
        repeat (2) @(negedge clk);
        check("flush done", 1, dFlush);
        check("interrupt", 1, dInt);
        check("nack pin", 0, link.inletNackFlag);
        send(8'h80, 53);
        expect_cell(8'h80);
        $display("ali test done");
        finish_test;
    end
endmodule
